// >>> dv/spfc_sva.sv
module spfc_sva
  import spm_ctrl_pkg::*;
#(
  parameter int PROG_CYC = 20 // flash write time in cycles
) (
  input wire logic ref_clk, // cpu clock
  input wire logic arst_n, // async reset, low active
  input wire logic [7:0] reg_rdata, // read data
  input wire logic global_irq_en, // status i-bit
  input wire logic eeprom_write_busy, // eeprom writing
  input wire logic store_req, // store pulse
  input wire logic load_req, // load pulse
  input wire logic load_override, // load answered
  input wire logic cpu_halt, // core stall
  input wire logic ready_irq, // ready request
  input wire logic flash_erase, // erase pulse
  input wire logic flash_write // write pulse
);
  localparam int HALT_LO = (PROG_CYC * 32) / 33; // 3.2 ms scaled
  localparam int HALT_HI = (PROG_CYC * 34) / 33 + 1; // 3.4 ms scaled
  logic [31:0] halt_cnt; // cycles spent halted
  logic [31:0] next_halt_cnt; // next count
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // count the halted stretch
  always_comb begin
    next_halt_cnt = cpu_halt ? halt_cnt + 32'h1 : '0;
  end
  // register the count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_cnt <= '0;
    end else begin
      halt_cnt <= next_halt_cnt;
    end
  end
  // operation pulse followed by a halted core
  sequence s_prog_start;
    (flash_write || flash_erase) ##1 cpu_halt;
  endsequence
  a_busy_reads_zero: assert property (reg_rdata[BIT_BUSY] == 1'b0)
    else $error("busy bit read as one");
  a_write_halts_core: assert property (flash_write |-> s_prog_start)
    else $error("core not halted for page write");
  a_erase_halts_core: assert property (flash_erase |-> s_prog_start)
    else $error("core not halted for page erase");
  a_halt_time_bound: assert property ($fell(cpu_halt) |-> halt_cnt >= HALT_LO && halt_cnt <= HALT_HI)
    else $error("programming time out of range");
  a_irq_eeprom_quiet: assert property (eeprom_write_busy |-> !ready_irq)
    else $error("ready irq during eeprom write");
  a_irq_needs_gie: assert property (ready_irq |-> global_irq_en && !cpu_halt)
    else $error("ready irq without global enable");
  a_write_from_store: assert property ((flash_write || flash_erase) |-> $past(store_req))
    else $error("page operation without store");
  a_load_from_req: assert property (load_override |-> $past(load_req))
    else $error("load answered without request");
  a_eeprom_blocks_prog: assert property (eeprom_write_busy throughout (store_req ##1 1'b1)
    |-> !(flash_write || flash_erase))
    else $error("programming during eeprom write");
endmodule : spfc_sva
bind self_program_flash_control spfc_sva #(.PROG_CYC(PROG_CYC)) u_sva (.ref_clk, .arst_n,
  .reg_rdata, .global_irq_en, .eeprom_write_busy, .store_req, .load_req, .load_override,
  .cpu_halt, .ready_irq, .flash_erase, .flash_write);

// >>> dv/spm_core_model.sv
module spm_core_model (
  input wire logic ref_clk, // cpu clock
  input wire logic cpu_halt, // stall from block
  output logic store_req, // store pulse
  output logic load_req, // load pulse
  output logic [15:0] ptr, // pointer
  output logic [15:0] store_data_pair // register pair
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle core, no request
  initial begin
    store_req = 1'b0;
    load_req = 1'b0;
    ptr = 16'h0000;
    store_data_pair = 16'h0000;
  end
  // one store or load, never while halted
  task automatic issue(input logic st, input logic [15:0] p, input logic [15:0] d);
    @(posedge ref_clk);
    while (cpu_halt === 1'b1) @(posedge ref_clk);
    #1;
    store_req = st;
    load_req = !st;
    ptr = p;
    store_data_pair = d;
    @(posedge ref_clk);
    #1;
    store_req = 1'b0;
    load_req = 1'b0;
    ptr = ~p; // stale operands do not linger
    store_data_pair = ~d;
  endtask : issue
endmodule : spm_core_model

// >>> dv/tb_self_program_flash_control.sv
module tb_self_program_flash_control;
  import spm_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, reg_io = 0; // bench drives
  logic global_irq_en = 0, eeprom_write_busy = 0; // status levels
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, load_data, q, ld; // bytes
  logic [7:0] lock_bits = 8'h3C, fuse_low = 8'hE2, fuse_high = 8'hDF, fuse_ext = 8'hF9;
  logic [7:0] sig_byte = 8'h5A; // arbitrary value
  logic store_req, load_req, load_override, cpu_halt, ready_irq, flash_erase, flash_write;
  logic [15:0] ptr, store_data_pair; // core operands
  logic [6:0] flash_page, pg; // page target
  logic [511:0] flash_wdata; // buffer image
  int errors = 0, tests_run = 0, n_wr = 0, n_er = 0; // counters
  self_program_flash_control #(.PROG_CYC(20)) DUT (.ref_clk, .arst_n, .reg_wr, .reg_rd,
    .reg_io, .reg_addr, .reg_wdata, .reg_rdata, .global_irq_en, .eeprom_write_busy,
    .store_req, .load_req, .ptr, .store_data_pair, .lock_bits, .fuse_low, .fuse_high,
    .fuse_ext, .sig_byte, .load_override, .load_data, .cpu_halt, .ready_irq, .flash_erase,
    .flash_write, .flash_page, .flash_wdata);
  spm_core_model cpu (.ref_clk, .cpu_halt, .store_req, .load_req, .ptr, .store_data_pair);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // capture pulses and load answers
  always @(posedge ref_clk) begin
    if (flash_write | flash_erase) pg <= flash_page;
    if (flash_write) n_wr++;
    if (flash_erase) n_er++;
    if (load_override) ld <= load_data;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr = 1;
    reg_io = 0;
    reg_addr = CTRL_DATA_ADDR;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic io);
    @(posedge ref_clk);
    #1;
    reg_rd = 1;
    reg_io = io;
    reg_addr = io ? CTRL_IO_ADDR : CTRL_DATA_ADDR;
    @(posedge ref_clk);
    #1;
    reg_rd = 0;
    q = reg_rdata;
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 60 && cpu_halt !== 1'b0; i++) @(posedge ref_clk);
    rd(0);
  endtask : wait_idle
  task automatic t_reset();
    rd(0);
    chk(q, CTRL_RESET);
    chk(flash_wdata[15:0], 16'hFFFF);
  endtask : t_reset
  task automatic t_fill();
    wr(CMD_LOAD);
    cpu.issue(1, 16'h0007, 16'hA55A);
    rd(0);
    chk(flash_wdata[63:48], 16'hA55A);
    chk(q, 8'h00);
    wr(CMD_REEN);
    cpu.issue(1, 16'h0000, 16'h0000);
    rd(0);
    chk(flash_wdata[63:48], 16'hFFFF);
  endtask : t_fill
  task automatic t_write();
    wr(CMD_LOAD);
    cpu.issue(1, 16'h0006, 16'h1234);
    wr(CMD_WRITE);
    cpu.issue(1, 16'h0FC0, 16'h0000);
    rd(0);
    chk(q, 8'h05);
    chk(cpu_halt, 1'b1);
    wait_idle();
    chk(q, 8'h00);
    chk(16'(n_wr), 16'h1);
    chk(pg, 7'h3F);
    chk(flash_wdata[63:48], 16'hFFFF);
  endtask : t_write
  task automatic t_erase();
    wr(CMD_ERASE);
    cpu.issue(1, 16'h0040, 16'hBEEF);
    rd(0);
    chk(cpu_halt, 1'b1);
    wait_idle();
    chk(q, 8'h00);
    chk(16'(n_er), 16'h1);
    chk(pg, 7'h01);
  endtask : t_erase
  task automatic t_window();
    wr(CMD_WRITE);
    repeat (5) @(posedge ref_clk);
    rd(0);
    chk(q, 8'h00);
    cpu.issue(1, 16'h0040, 16'h0000);
    wr(CMD_WRITE);
    repeat (1) @(posedge ref_clk);
    wr(CMD_WRITE);
    repeat (2) @(posedge ref_clk);
    cpu.issue(1, 16'h0080, 16'h0000);
    wait_idle();
    chk(16'(n_wr), 16'h2);
    chk(pg, 7'h02);
  endtask : t_window
  task automatic t_lock();
    wr(CMD_LOCK);
    cpu.issue(0, PTR_LOCK, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk(ld, lock_bits);
    wr(CMD_LOCK);
    cpu.issue(0, PTR_FUSE_LOW, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk(ld, fuse_low);
    wr(8'h21);
    cpu.issue(0, 16'h0000, 16'h0000);
    cpu.issue(1, 16'h0040, 16'h0000);
    chk(ld, sig_byte);
    wr(8'h07);
    rd(0);
    chk(q, 8'h00);
    cpu.issue(1, 16'h0040, 16'h0000);
    wait_idle();
    chk(16'(n_wr + n_er), 16'h3);
  endtask : t_lock
  task automatic t_irq();
    wr(8'h80);
    global_irq_en = 1;
    rd(1);
    chk(q, 8'h80);
    chk(ready_irq, 1'b1);
    eeprom_write_busy = 1;
    #1;
    chk(ready_irq, 1'b0);
    global_irq_en = 0;
    wr(8'h85);
    cpu.issue(1, 16'h0040, 16'h0000);
    wait_idle();
    chk(16'(n_wr), 16'h2);
    eeprom_write_busy = 0;
  endtask : t_irq
  task automatic finish_test();
    if (errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  initial begin
    #100us;
    errors++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    arst_n = 1;
    t_reset();
    t_fill();
    t_write();
    t_erase();
    t_window();
    t_lock();
    t_irq();
    finish_test();
  end
endmodule : tb_self_program_flash_control

// >>> hdl/page_buf_if.sv
interface page_buf_if #(parameter int WORDS = 32, parameter int AW = 5);
  logic wr_en; // store one word
  logic [AW-1:0] wr_addr; // word index
  logic [15:0] wr_data; // word value
  logic clear; // wipe whole buffer
  logic [16*WORDS-1:0] words; // whole buffer contents
  modport owner (input wr_en, input wr_addr, input wr_data, input clear, output words);
  modport user (output wr_en, output wr_addr, output wr_data, output clear, input words);
endinterface : page_buf_if

// >>> hdl/page_buffer.sv
module page_buffer
  import spm_ctrl_pkg::*;
#(
  parameter int WORDS = 32 // words per page
) (
  input wire logic ref_clk, // cpu clock
  input wire logic arst_n, // async reset, low active
  page_buf_if.owner pb // buffer port
);
  logic [15:0] mem [WORDS]; // word storage
  logic [15:0] next_mem [WORDS]; // next word storage

  // per word: clear, store, or hold
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      if (pb.clear) begin
        next_mem[i] = 16'hFFFF;
      end else if (pb.wr_en && (int'(pb.wr_addr) == i)) begin
        next_mem[i] = pb.wr_data;
      end else begin
        next_mem[i] = mem[i];
      end
    end
  end

  // register words; reset erases
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < WORDS; i++) mem[i] <= 16'hFFFF;
    end else begin
      mem <= next_mem;
    end
  end

  // flatten for the flash side
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_flat
      assign pb.words[16*g +: 16] = mem[g];
    end
  endgenerate
endmodule : page_buffer

// >>> hdl/prog_timer.sv
module prog_timer
  import spm_ctrl_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES // programming time in cycles
) (
  input wire logic ref_clk, // cpu clock
  input wire logic arst_n, // async reset, low active
  input wire logic start, // begin a timed write
  output logic busy, // timing in progress
  output logic done // one-cycle end pulse
);
  logic [31:0] count; // cycles remaining
  logic [31:0] next_count;
  logic next_done;

  // count down from start to zero
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start && count == 32'h0) begin
      next_count = 32'(CYCLES);
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
      next_done = (count == 32'h1);
    end
  end

  // register counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 32'h0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy = (count != 32'h0);
endmodule : prog_timer

// >>> hdl/self_program_flash_control.sv
module self_program_flash_control
  import spm_ctrl_pkg::*;
#(
  parameter int PAGE_WORDS = 32, // words per page
  parameter int PAGE_AW = 5, // word index width
  parameter int PAGE_BITS = 7, // page number width
  parameter int PROG_CYC = PROG_CYCLES // flash write time in cycles
) (
  input wire logic ref_clk, // cpu clock
  input wire logic arst_n, // async reset, low active
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic reg_io, // address is i/o space
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  input wire logic global_irq_en, // status i-bit
  input wire logic eeprom_write_busy, // data eeprom writing
  input wire logic store_req, // store instruction issued
  input wire logic load_req, // load instruction issued
  input wire logic [15:0] ptr, // z pointer
  input wire logic [15:0] store_data_pair, // register pair value
  input wire logic [7:0] lock_bits, // lock byte
  input wire logic [7:0] fuse_low, // fuse low byte
  input wire logic [7:0] fuse_high, // fuse high byte
  input wire logic [7:0] fuse_ext, // extended fuse byte
  input wire logic [7:0] sig_byte, // signature row byte
  output logic load_override, // load answered here
  output logic [7:0] load_data, // byte returned to load
  output logic cpu_halt, // stall the core
  output logic ready_irq, // ready interrupt request
  output logic flash_erase, // erase page pulse
  output logic flash_write, // write page pulse
  output logic [PAGE_BITS-1:0] flash_page, // page target
  output logic [16*PAGE_WORDS-1:0] flash_wdata // page data
);
  page_buf_if #(.WORDS(PAGE_WORDS), .AW(PAGE_AW)) pb ();

  // control register state
  // the enable bit and the command bits live here;
  // the busy bit has no storage, it always reads zero
  logic irq_en; // ready irq enable bit
  logic [4:0] cmd; // lower control bits
  logic [2:0] window; // cycles left in arm window
  op_kind_t op; // armed or running op
  logic running; // erase/write in progress
  logic [PAGE_BITS-1:0] page; // latched page

  // load answer state
  // a load inside the short window in lock or signature mode is answered here
  // instead of by the program memory
  logic [7:0] ldata; // load result
  logic lovr; // load override valid

  // flash command pulses, one cycle each
  logic erase_p; // erase start pulse
  logic write_p; // write start pulse

  // next values, one per register above
  logic [7:0] next_ldata; // next load result
  logic next_lovr; // next override flag
  logic next_erase_p; // next erase pulse
  logic next_write_p; // next write pulse
  logic [7:0] rdata_q; // registered read data
  logic [7:0] next_rdata; // next read data
  logic next_irq_en; // next irq enable
  logic [4:0] next_cmd; // next command bits
  logic [2:0] next_window; // next window count
  op_kind_t next_op; // next operation
  logic next_running; // next running flag
  logic [PAGE_BITS-1:0] next_page; // next page target

  // timer handshakes
  logic tstart; // start the timed write
  logic tbusy; // timer still counting
  logic tdone; // timer end pulse

  // decode and buffer controls
  logic hit; // register address matches
  logic buf_clear; // wipe whole buffer
  logic buf_wr; // store one buffer word

  // address decode for both spaces
  assign hit = reg_io ? (reg_addr == CTRL_IO_ADDR) : (reg_addr == CTRL_DATA_ADDR);

  page_buffer #(.WORDS(PAGE_WORDS)) u_buf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pb(pb.owner)
  );

  prog_timer #(.CYCLES(PROG_CYC)) u_timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .start(tstart),
    .busy(tbusy),
    .done(tdone)
  );

  // sequencing overview
  // three phases, checked in priority order:
  //  running - a timed erase or write owns the block;
  //            register writes are ignored until it ends
  //  write   - a register write arms a new command and
  //            restarts the four-cycle window
  //  window  - while armed, a store or a load may act;
  //            an unused window clears the command bits
  // the window counts down from four, so the load part
  // of the window is the first three counts only
  // a data eeprom write in flight blocks any arming,
  // which also blocks lock and fuse read-back
  // illegal codes leave the lower bits at zero

  // command, window and operation sequencing
  always_comb begin
    next_irq_en = irq_en;
    next_cmd = cmd;
    next_window = window;
    next_op = op;
    next_running = running;
    next_page = page;
    next_ldata = ldata;
    next_lovr = 1'b0;
    next_erase_p = 1'b0;
    next_write_p = 1'b0;
    tstart = 1'b0;
    buf_clear = 1'b0;
    buf_wr = 1'b0;
    if (running) begin
      // hold enable until the timed write ends
      if (tdone) begin
        next_running = 1'b0;
        next_cmd = 5'h00;
        next_op = OP_NONE;
        if (op == OP_WRITE) buf_clear = 1'b1;
      end
    end else if (reg_wr && hit) begin
      // a new write restarts the window unless eeprom-blocked or an illegal code
      // and drops whatever was armed before
      next_irq_en = reg_wdata[BIT_IRQ_EN];
      next_window = STORE_WINDOW;
      next_cmd = 5'h00;
      next_op = OP_NONE;
      if (!eeprom_write_busy) begin
        next_cmd = reg_wdata[4:0];
        case (reg_wdata[4:0])
          CMD_LOAD: next_op = OP_LOAD;
          CMD_ERASE: next_op = OP_ERASE;
          CMD_WRITE: next_op = OP_WRITE;
          CMD_LOCK: next_op = OP_LOCK;
          CMD_REEN: begin
            next_op = OP_NONE;
            buf_clear = 1'b1;
          end
          default: begin
            next_op = OP_NONE;
            next_cmd = 5'h00;
          end
        endcase
        if (reg_wdata[BIT_SIG] && reg_wdata[BIT_OP_EN] && reg_wdata[4:1] == 4'h0) begin
          next_op = OP_SIG;
        end
        if (next_op == OP_NONE && reg_wdata[4:0] != CMD_REEN) next_window = 3'h0;
      end else begin
        next_window = 3'h0;
      end
    end else if (window != 3'h0) begin
      // armed: count the window down
      // the first three counts also accept a load
      next_window = window - 3'h1;
      if (load_req && (STORE_WINDOW - window) < LOAD_WINDOW) begin
        // load inside the three-cycle window
        if (op == OP_LOCK) begin
          next_lovr = 1'b1;
          case (ptr[1:0])
            PTR_FUSE_LOW[1:0]: next_ldata = fuse_low;
            PTR_LOCK[1:0]: next_ldata = lock_bits;
            2'b10: next_ldata = fuse_ext;
            default: next_ldata = fuse_high;
          endcase
          next_cmd = 5'h00;
          next_window = 3'h0;
          next_op = OP_NONE;
        end else if (op == OP_SIG) begin
          next_lovr = 1'b1;
          next_ldata = sig_byte;
        end
      end
      // store: consumes the window whatever it does
      // erase and write keep the bits until the timer ends
      if (store_req) begin
        next_window = 3'h0;
        next_cmd = 5'h00;
        next_op = OP_NONE;
        case (op)
          OP_LOAD: buf_wr = 1'b1;
          OP_ERASE, OP_WRITE: begin
            next_page = ptr[PAGE_AW+1 +: PAGE_BITS];
            next_cmd = cmd;
            next_op = op;
            next_running = 1'b1;
            tstart = 1'b1;
            next_erase_p = (op == OP_ERASE);
            next_write_p = (op == OP_WRITE);
          end
          default: next_op = OP_NONE; // signature mode store ignored
        endcase
      end else if (window == 3'h1) begin
        // last count with no store: give up
        next_cmd = 5'h00;
        next_op = OP_NONE;
      end
    end
  end

  // buffer port
  // word index skips the pointer byte bit;
  // a clear outranks a store in the same cycle
  assign pb.clear = buf_clear;
  assign pb.wr_en = buf_wr;
  assign pb.wr_addr = ptr[PAGE_AW:1];
  assign pb.wr_data = store_data_pair;

  // read data mux
  // the busy bit is a constant zero;
  // bit 5 shows the armed signature mode
  always_comb begin
    next_rdata = rdata_q;
    if (reg_rd && hit) begin
      next_rdata = {irq_en, 1'b0, (op == OP_SIG), cmd};
    end
  end

  // register all state
  // reset gives the documented zero register value,
  // an idle window and no operation
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en <= CTRL_RESET[BIT_IRQ_EN];
      cmd <= CTRL_RESET[4:0];
      window <= 3'h0;
      op <= OP_NONE;
      running <= 1'b0;
      page <= '0;
      ldata <= 8'h00;
      lovr <= 1'b0;
      erase_p <= 1'b0;
      write_p <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      irq_en <= next_irq_en;
      cmd <= next_cmd;
      window <= next_window;
      op <= next_op;
      running <= next_running;
      page <= next_page;
      ldata <= next_ldata;
      lovr <= next_lovr;
      erase_p <= next_erase_p;
      write_p <= next_write_p;
      rdata_q <= next_rdata;
    end
  end

  // outputs
  // all data outputs come straight from flip-flops;
  // the halt covers the whole timed operation,
  // including the cycle in which the timer ends
  assign reg_rdata = rdata_q;
  assign load_override = lovr;
  assign load_data = ldata;
  assign cpu_halt = running | tbusy;
  assign flash_erase = erase_p;
  assign flash_write = write_p;
  assign flash_page = page;
  assign flash_wdata = pb.words;
  // ready irq held while enable bit clear, masked when busy
  assign ready_irq = irq_en & global_irq_en & ~cmd[BIT_OP_EN] & ~eeprom_write_busy
                   & ~running;
endmodule : self_program_flash_control

// >>> hdl/spm_ctrl_pkg.sv
package spm_ctrl_pkg;
  // register addresses
  localparam logic [7:0] CTRL_DATA_ADDR = 8'h57; // data-space address
  localparam logic [7:0] IO_ADDR_DELTA = 8'h20; // i/o address offset
  localparam logic [7:0] CTRL_IO_ADDR = CTRL_DATA_ADDR - IO_ADDR_DELTA;
  localparam logic [7:0] CTRL_RESET = 8'h00; // value after reset
  // control bit positions
  localparam int BIT_OP_EN = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_WRITE = 2;
  localparam int BIT_LOCK = 3;
  localparam int BIT_REEN = 4;
  localparam int BIT_SIG = 5;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  // legal command codes in the lower five bits
  localparam logic [4:0] CMD_LOAD = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_REEN = 5'h11;
  // arming windows in cycles
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW = 3'h3;
  // lock/fuse pointer selection
  localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  // flash write time
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 3300; // inside 3.2 ms .. 3.4 ms
  localparam int PROG_MIN_US = 3200;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  // operation kinds
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOAD = 3'b001,
    OP_ERASE = 3'b010,
    OP_WRITE = 3'b011,
    OP_LOCK = 3'b100,
    OP_SIG = 3'b101
  } op_kind_t;
endpackage : spm_ctrl_pkg
